// file: shared/fsc_consts.svh
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// factory default images, 0 = programmed, 1 = unprogrammed
`define FSC_EXT_DEF_SMALL   8'hff
`define FSC_EXT_DEF_LARGE   8'hf9
`define FSC_HIGH_DEF        8'hdf
`define FSC_LOW_DEF         8'h62
`define FSC_LOCK_DEF        8'hff
// implemented bits per byte, others read back as 1
`define FSC_EXT_USED_SMALL  8'h01
`define FSC_EXT_USED_LARGE  8'h07
`define FSC_LOCK_USED_SMALL 8'h03
`define FSC_LOCK_USED_LARGE 8'h3f
// single bit positions
`define FSC_EXT_RVEC        0
`define FSC_HI_RSTOFF       7
`define FSC_HI_DEBUG        6
`define FSC_HI_SPROG        5
`define FSC_HI_WDOG         4
`define FSC_HI_EEKEEP       3
`define FSC_LO_DIV8         7
`define FSC_LO_CLOCK_PIN_OUTPUT        6
`define FSC_LOCK_FIRST      0
// multi bit fields
`define FSC_EXT_BOOT_MSB    2
`define FSC_EXT_BOOT_LSB    1
`define FSC_HI_BOD_MSB      2
`define FSC_HI_BOD_LSB      0
`define FSC_LO_SUT_MSB      5
`define FSC_LO_SUT_LSB      4
`define FSC_LO_CKSRC_MSB    3
`define FSC_LO_CKSRC_LSB    0
// single bit masks and the empty mask
`define FSC_SPROG_MASK      8'h20
`define FSC_EEKEEP_MASK     8'h08
`define FSC_NONE_MASK       8'h00
// address space codes
`define FSC_SP_EXT          3'h0
`define FSC_SP_HIGH         3'h1
`define FSC_SP_LOW          3'h2
`define FSC_SP_LOCK         3'h3
`define FSC_SP_SIG          3'h4
`define FSC_SP_CAL          3'h5
// signature addresses
`define FSC_SIG_ADDR0       2'h0
`define FSC_SIG_ADDR1       2'h1
`define FSC_SIG_ADDR2       2'h2
// busy times in clock cycles
`define FSC_WRITE_CYCLES    16'h0008
`define FSC_ERASE_CYCLES    16'h0020
`define FSC_CNT_ONE         16'h0001
`define FSC_CNT_ZERO        16'h0000
// page geometry
`define FSC_FLASH_WORD_SMALL 5
`define FSC_FLASH_WORD_LARGE 6
`define FSC_EE_BYTE_BITS    2
`endif

// file: shared/fsc_pkg.sv
package fsc_pkg;
`include "fsc_consts.svh"
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        FSC_ST_IDLE  = 3'b001,
        FSC_ST_PROG  = 3'b010,
        FSC_ST_ERASE = 3'b100
    } fsc_state_t;
    // programming address spaces
    typedef enum logic [2:0] {
        FSC_EXT  = `FSC_SP_EXT,
        FSC_HIGH = `FSC_SP_HIGH,
        FSC_LOW  = `FSC_SP_LOW,
        FSC_LOCK = `FSC_SP_LOCK,
        FSC_SIG  = `FSC_SP_SIG,
        FSC_CAL  = `FSC_SP_CAL
    } fsc_space_t;
endpackage

// file: shared/fsc_if.sv
`timescale 1ns/1ps
// one fuse byte: stored image towards its working latch
interface fsc_if;
    logic       load;   // capture stored image
    logic [7:0] nv;     // stored image
    logic [7:0] work;   // working copy
    modport ctrl_mp  (output load, output nv, input work);
    modport latch_mp (input load, input nv, output work);
endinterface // fsc_if

// file: hw/fsc_latch.sv
`timescale 1ns/1ps
// working latch for one fuse byte
module fsc_latch #(
    parameter logic [7:0] RESET_VAL = 8'hff, // value before first capture
    parameter logic [7:0] IMM_MASK  = 8'h00  // bits that follow programming at once
) (
    input  wire logic   clock_i,
    input  wire logic   rst_b_i,
    fsc_if.latch_mp     lt
);
    logic [7:0] work_ff;  // held copy
    logic [7:0] nxt_work; // next copy

    // capture wins; otherwise hold, except immediate bits that got programmed
    // other bits stable between captures
    assign nxt_work = lt.load ? lt.nv : (work_ff & ~(IMM_MASK & ~lt.nv));

    // latch register
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            work_ff <= RESET_VAL;
        end else begin
            work_ff <= nxt_work;
        end
    end

    assign lt.work = work_ff;
endmodule // fsc_latch

// file: hw/fsc_store.sv
`timescale 1ns/1ps
`include "fsc_consts.svh"
// Summary of operation
// - programmed fuse reads 0, unprogrammed 1
// - extended byte: boot size, reset vector
// - serial programming allow defaults programmed
// - serial mode cannot touch serial allow
// - reset off, debug, watchdog default 1
// - eeprom keep fuse spares eeprom on erase
// - three brownout level bits default 1
// - divide by eight, clock pin output
// - start-up time field defaults 10
// - clock source field defaults 0010
// - chip erase leaves fuses unchanged
// - first lock bit blocks fuse writes
// - fuses latch on programming mode entry
// - eeprom keep takes effect at once when programmed
// - fuses latch at power-up too
// - three signature bytes at 0,1,2
// - signature readable whatever the lock
// - calibration byte at address 0 of its own space
// - every reset loads calibration into trim
// - flash page word index and page
// - eeprom four-byte pages
// - chip erase returns lock bits to 1
module fsc_store #(
    parameter bit         LARGE_VARIANT = 1'b1,  // boot size field present
    parameter bit         BIG_FLASH     = 1'b0,  // 64-word flash pages
    parameter int         PC_W          = 12,    // program counter width
    parameter int         EEA_W         = 9,     // eeprom address width
    parameter logic [7:0] SIG_BYTE0     = 8'h5a, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1     = 8'h3c, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2     = 8'h0f, // arbitrary identity value
    parameter logic [7:0] CAL_BYTE      = 8'h80, // factory trim value
    parameter logic [15:0] WRITE_CYCLES = `FSC_WRITE_CYCLES,
    parameter logic [15:0] ERASE_CYCLES = `FSC_ERASE_CYCLES,
    localparam int        WB            = BIG_FLASH ? `FSC_FLASH_WORD_LARGE
                                                    : `FSC_FLASH_WORD_SMALL
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        sys_reset_i,
    input  wire logic                        prog_mode_i,
    input  wire logic                        prog_serial_i,
    input  wire logic                        req_valid_i,
    input  wire logic                        req_write_i,
    input  wire logic                        req_erase_i,
    input  wire logic [2:0]                  req_space_i,
    input  wire logic [1:0]                  req_addr_i,
    input  wire logic [7:0]                  req_wdata_i,
    output logic                             req_ready_o,
    output logic                             rsp_valid_o,
    output logic [7:0]                       rsp_data_o,
    output logic                             refused_o,
    output logic                             flash_erase_o,
    output logic                             eeprom_erase_o,
    output logic                             self_program_allow_o,
    output logic                             boot_size_sel_hi_o,
    output logic                             boot_size_sel_lo_o,
    output logic                             reset_vector_sel_o,
    output logic                             ext_reset_off_o,
    output logic                             onchip_debug_on_o,
    output logic                             serial_prog_allow_o,
    output logic                             watchdog_forced_on_o,
    output logic                             eeprom_keep_on_erase_o,
    output logic [2:0]                       brownout_level_o,
    output logic                             clock_div_eight_o,
    output logic                             clock_pin_output_o,
    output logic [1:0]                       startup_time_o,
    output logic [3:0]                       clock_source_o,
    output logic [7:0]                       lock_bits_o,
    output logic [7:0]                       rc_osc_trim_reg_o,
    input  wire logic [PC_W-1:0]             pc_i,
    input  wire logic [EEA_W-1:0]            eea_i,
    output logic [WB-1:0]                    word_in_page_index_o,
    output logic [PC_W-WB-1:0]               page_select_index_o,
    output logic [`FSC_EE_BYTE_BITS-1:0]     ee_byte_o,
    output logic [EEA_W-`FSC_EE_BYTE_BITS-1:0] ee_page_o
);
    // variant dependent images
    localparam logic [7:0] EXT_DEF   = LARGE_VARIANT ? `FSC_EXT_DEF_LARGE
                                                     : `FSC_EXT_DEF_SMALL;
    localparam logic [7:0] EXT_USED  = LARGE_VARIANT ? `FSC_EXT_USED_LARGE
                                                     : `FSC_EXT_USED_SMALL;
    localparam logic [7:0] LOCK_USED = LARGE_VARIANT ? `FSC_LOCK_USED_LARGE
                                                     : `FSC_LOCK_USED_SMALL;

    // stored (non-volatile) images, set to factory defaults by a cold reset, the lock byte also by chip erase
    logic [7:0]             ext_nv_ff;   // extended fuse byte
    logic [7:0]             hi_nv_ff;    // high fuse byte
    logic [7:0]             lo_nv_ff;    // low fuse byte
    logic [7:0]             lock_nv_ff;  // lock bit byte
    // sequencer
    fsc_pkg::fsc_state_t    state_ff;    // current state
    fsc_pkg::fsc_state_t    nxt_state;   // next state
    logic [15:0]            cnt_ff;      // busy countdown
    logic [15:0]            nxt_cnt;     // next countdown
    logic [2:0]             pend_sp_ff;  // space of pending write
    logic [7:0]             pend_dat_ff; // merged data of pending write
    // answers
    logic                   rsp_vld_ff;  // read answer strobe
    logic [7:0]             rsp_dat_ff;  // read answer data
    logic                   refused_ff;  // refused request strobe
    logic                   ferase_ff;   // flash erase strobe
    logic                   eerase_ff;   // eeprom erase strobe
    logic [7:0]             trim_ff;     // oscillator trim
    // capture control
    logic                   boot_ff;     // first cycle after power-up
    logic                   mode_d_ff;   // mode seen last cycle

    // per byte carriers to the working latches
    fsc_if ext_if ();
    fsc_if hi_if ();
    fsc_if lo_if ();

    // decode of the incoming request
    wire take      = req_valid_i & req_ready_o;
    wire take_rd   = take & ~req_write_i & ~req_erase_i;
    wire take_er   = take & req_erase_i;
    wire take_wr   = take & req_write_i & ~req_erase_i;
    wire sp_fuse   = (req_space_i == `FSC_SP_EXT) | (req_space_i == `FSC_SP_HIGH)
                   | (req_space_i == `FSC_SP_LOW);
    wire sp_lock   = req_space_i == `FSC_SP_LOCK;
    wire locked    = ~lock_nv_ff[`FSC_LOCK_FIRST];
    wire wr_ok     = (sp_fuse & ~locked) | sp_lock;
    wire wr_go     = take_wr & wr_ok;
    wire is_idle   = state_ff == fsc_pkg::FSC_ST_IDLE;
    wire cnt_done  = cnt_ff == `FSC_CNT_ZERO;
    wire commit    = (state_ff == fsc_pkg::FSC_ST_PROG) & cnt_done;
    wire er_done   = (state_ff == fsc_pkg::FSC_ST_ERASE) & cnt_done;

    // serial mode keeps serial allow bit as stored
    wire [7:0] hi_wr  = prog_serial_i
                      ? ((req_wdata_i & ~`FSC_SPROG_MASK) | (hi_nv_ff & `FSC_SPROG_MASK))
                      : req_wdata_i;
    // unused extended bits forced to 1
    wire [7:0] ext_wr = req_wdata_i | ~EXT_USED;
    // lock bits only ever programmed by a write
    wire [7:0] lock_wr = lock_nv_ff & (req_wdata_i | ~LOCK_USED);
    wire [7:0] merged = (req_space_i == `FSC_SP_EXT)  ? ext_wr
                      : (req_space_i == `FSC_SP_HIGH) ? hi_wr
                      : (req_space_i == `FSC_SP_LOCK) ? lock_wr
                      : req_wdata_i;

    // signature bytes by address, calibration at address 0
    wire [7:0] sig_rd = (req_addr_i == `FSC_SIG_ADDR0) ? SIG_BYTE0
                      : (req_addr_i == `FSC_SIG_ADDR1) ? SIG_BYTE1
                      : (req_addr_i == `FSC_SIG_ADDR2) ? SIG_BYTE2
                      : 8'hff;
    wire [7:0] cal_rd = (req_addr_i == `FSC_SIG_ADDR0) ? CAL_BYTE : 8'hff;
    // serial allow bit hidden in serial mode
    wire [7:0] hi_rd  = prog_serial_i ? (hi_nv_ff | `FSC_SPROG_MASK) : hi_nv_ff;
    wire [7:0] rd_mux = (req_space_i == `FSC_SP_EXT)  ? ext_nv_ff
                      : (req_space_i == `FSC_SP_HIGH) ? hi_rd
                      : (req_space_i == `FSC_SP_LOW)  ? lo_nv_ff
                      : (req_space_i == `FSC_SP_LOCK) ? lock_nv_ff
                      : (req_space_i == `FSC_SP_SIG)  ? sig_rd
                      : (req_space_i == `FSC_SP_CAL)  ? cal_rd
                      : 8'hff;

    // requests only in programming mode while nothing is running
    assign req_ready_o = is_idle & prog_mode_i;

    // sequencer next state, plain case
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            fsc_pkg::FSC_ST_IDLE: begin
                if (take_er) begin
                    nxt_state = fsc_pkg::FSC_ST_ERASE;
                    nxt_cnt   = ERASE_CYCLES - `FSC_CNT_ONE;
                end else if (wr_go) begin
                    nxt_state = fsc_pkg::FSC_ST_PROG;
                    nxt_cnt   = WRITE_CYCLES - `FSC_CNT_ONE;
                end
            end
            fsc_pkg::FSC_ST_PROG, fsc_pkg::FSC_ST_ERASE: begin
                if (cnt_done) begin
                    nxt_state = fsc_pkg::FSC_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - `FSC_CNT_ONE;
                end
            end
            default: begin
                nxt_state = fsc_pkg::FSC_ST_IDLE;
                nxt_cnt   = `FSC_CNT_ZERO;
            end
        endcase
    end

    // sequencer registers and pending write
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff    <= fsc_pkg::FSC_ST_IDLE;
            cnt_ff      <= `FSC_CNT_ZERO;
            pend_sp_ff  <= `FSC_SP_EXT;
            pend_dat_ff <= 8'hff;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (wr_go && !take_er) begin
                pend_sp_ff  <= req_space_i;
                pend_dat_ff <= merged;
            end
        end
    end

    // stored images; a write lands only when its busy time ends
    // factory defaults
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_nv_ff  <= EXT_DEF;
            hi_nv_ff   <= `FSC_HIGH_DEF;
            lo_nv_ff   <= `FSC_LOW_DEF;
            lock_nv_ff <= `FSC_LOCK_DEF;
        end else if (commit) begin
            case (pend_sp_ff)
                `FSC_SP_EXT:  ext_nv_ff  <= pend_dat_ff;
                `FSC_SP_HIGH: hi_nv_ff   <= pend_dat_ff;
                `FSC_SP_LOW:  lo_nv_ff   <= pend_dat_ff;
                `FSC_SP_LOCK: lock_nv_ff <= pend_dat_ff;
                default:      lock_nv_ff <= lock_nv_ff;
            endcase
        end else if (er_done) begin
            lock_nv_ff <= `FSC_LOCK_DEF;
        end
    end

    // answer strobes and erase outputs
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_vld_ff <= 1'b0;
            rsp_dat_ff <= 8'h00;
            refused_ff <= 1'b0;
            ferase_ff  <= 1'b0;
            eerase_ff  <= 1'b0;
        end else begin
            // reads never look at the lock bits
            rsp_vld_ff <= take_rd;
            if (take_rd) begin
                rsp_dat_ff <= rd_mux;
            end
            refused_ff <= take_wr & ~wr_ok;
            ferase_ff  <= er_done;
            // eeprom spared while keep fuse programmed
            eerase_ff  <= er_done & hi_if.work[`FSC_HI_EEKEEP];
        end
    end

    // trim register, reloaded on every reset
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trim_ff <= CAL_BYTE;
        end else if (sys_reset_i) begin
            trim_ff <= CAL_BYTE;
        end
    end

    // capture events: power-up, mode entry and mode exit
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_ff   <= 1'b1;
            mode_d_ff <= 1'b0;
        end else begin
            boot_ff   <= 1'b0;
            mode_d_ff <= prog_mode_i;
        end
    end

    // capture on power-up and mode change
    wire load = boot_ff | (prog_mode_i ^ mode_d_ff);
    assign ext_if.load = load;
    assign hi_if.load  = load;
    assign lo_if.load  = load;
    assign ext_if.nv   = ext_nv_ff;
    assign hi_if.nv    = hi_nv_ff;
    assign lo_if.nv    = lo_nv_ff;

    // working latches; only the eeprom keep bit follows programming at once
    fsc_latch #(.RESET_VAL(EXT_DEF), .IMM_MASK(`FSC_NONE_MASK)) u_ext_latch (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .lt      (ext_if)
    );
    fsc_latch #(.RESET_VAL(`FSC_HIGH_DEF), .IMM_MASK(`FSC_EEKEEP_MASK)) u_hi_latch (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .lt      (hi_if)
    );
    fsc_latch #(.RESET_VAL(`FSC_LOW_DEF), .IMM_MASK(`FSC_NONE_MASK)) u_lo_latch (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .lt      (lo_if)
    );

    // field outputs from the working copies, lock bits from the stored image
    assign self_program_allow_o   = ext_if.work[`FSC_EXT_RVEC];
    assign boot_size_sel_hi_o     = ext_if.work[`FSC_EXT_BOOT_MSB];
    assign boot_size_sel_lo_o     = ext_if.work[`FSC_EXT_BOOT_LSB];
    assign reset_vector_sel_o     = ext_if.work[`FSC_EXT_RVEC];
    assign ext_reset_off_o        = hi_if.work[`FSC_HI_RSTOFF];
    assign onchip_debug_on_o      = hi_if.work[`FSC_HI_DEBUG];
    assign serial_prog_allow_o    = hi_if.work[`FSC_HI_SPROG];
    assign watchdog_forced_on_o   = hi_if.work[`FSC_HI_WDOG];
    assign eeprom_keep_on_erase_o = hi_if.work[`FSC_HI_EEKEEP];
    assign brownout_level_o       = hi_if.work[`FSC_HI_BOD_MSB:`FSC_HI_BOD_LSB];
    assign clock_div_eight_o      = lo_if.work[`FSC_LO_DIV8];
    assign clock_pin_output_o     = lo_if.work[`FSC_LO_CLOCK_PIN_OUTPUT];
    assign startup_time_o         = lo_if.work[`FSC_LO_SUT_MSB:`FSC_LO_SUT_LSB];
    assign clock_source_o         = lo_if.work[`FSC_LO_CKSRC_MSB:`FSC_LO_CKSRC_LSB];
    assign lock_bits_o            = lock_nv_ff;
    assign rc_osc_trim_reg_o      = trim_ff;
    assign rsp_valid_o            = rsp_vld_ff;
    assign rsp_data_o             = rsp_dat_ff;
    assign refused_o              = refused_ff;
    assign flash_erase_o          = ferase_ff;
    assign eeprom_erase_o         = eerase_ff;

    // flash word index and page split
    assign word_in_page_index_o   = pc_i[WB-1:0];
    assign page_select_index_o    = pc_i[PC_W-1:WB];
    // eeprom byte in page and page
    assign ee_byte_o              = eea_i[`FSC_EE_BYTE_BITS-1:0];
    assign ee_page_o              = eea_i[EEA_W-1:`FSC_EE_BYTE_BITS];

    // checks on the behaviour above
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    mode_entry_a: assert property (
        prog_mode_i && !mode_d_ff |=> lo_if.work == $past(lo_nv_ff))
        else $error("low byte not captured on mode entry");
    latch_hold_a: assert property (
        !load |=> lo_if.work == $past(lo_if.work))
        else $error("low working byte changed without capture");
    lock_refuse_a: assert property (
        take_wr && sp_fuse && locked |=> refused_o && is_idle)
        else $error("fuse write accepted while locked");
    erase_fuse_a: assert property (
        er_done |=> hi_nv_ff == $past(hi_nv_ff) && lo_nv_ff == $past(lo_nv_ff))
        else $error("chip erase changed fuses");
    erase_lock_a: assert property (
        er_done |=> lock_nv_ff == `FSC_LOCK_DEF && flash_erase_o)
        else $error("chip erase left lock bits programmed");
    sig_read_a: assert property (
        take_rd && req_space_i == `FSC_SP_SIG && req_addr_i == `FSC_SIG_ADDR0
        |=> rsp_valid_o && rsp_data_o == SIG_BYTE0)
        else $error("signature byte zero misread");
    trim_load_a: assert property (
        sys_reset_i |=> rc_osc_trim_reg_o == CAL_BYTE)
        else $error("trim not reloaded on reset");
    serial_keep_a: assert property (
        commit && prog_serial_i && pend_sp_ff == `FSC_SP_HIGH
        |=> hi_nv_ff[`FSC_HI_SPROG] == $past(hi_nv_ff[`FSC_HI_SPROG]))
        else $error("serial mode altered serial allow");
    keep_now_a: assert property (
        !hi_nv_ff[`FSC_HI_EEKEEP] |=> !eeprom_keep_on_erase_o)
        else $error("eeprom keep not effective at once");
    ro_write_a: assert property (
        take_wr && (req_space_i == `FSC_SP_SIG || req_space_i == `FSC_SP_CAL)
        |=> refused_o ##1 is_idle)
        else $error("read-only write not refused");
    write_busy_a: assert property (
        wr_go |=> !req_ready_o [*2])
        else $error("write busy time too short");
endmodule // fsc_store

// file: testbench/fsc_prog_model.sv
`timescale 1ns/1ps
// programmer side: one request at a time, held until taken
module fsc_prog_model (
    input  wire logic       clock_i,
    input  wire logic       ready_i,
    input  wire logic       rsp_valid_i,
    input  wire logic [7:0] rsp_data_i,
    input  wire logic       refused_i,
    output logic            valid_o,
    output logic            write_o,
    output logic            erase_o,
    output logic [2:0]      space_o,
    output logic [1:0]      addr_o,
    output logic [7:0]      wdata_o
);
    logic [7:0] last_data; // answer of the last read
    logic       last_ref;  // refusal pulse of the last write
    initial {valid_o, write_o, erase_o, space_o, addr_o, wdata_o} = '0;
    // drive on the falling edge, hold until a rising edge sees ready
    task automatic xfer(input logic wr, input logic er, input logic [2:0] sp,
                        input logic [1:0] ad, input logic [7:0] wd);
        @(negedge clock_i);
        {valid_o, write_o, erase_o, space_o, addr_o, wdata_o} = {1'b1, wr, er, sp, ad, wd};
        do @(posedge clock_i); while (ready_i !== 1'b1);
        @(negedge clock_i);
        valid_o = 1'b0;
        // released data bus must not keep showing the old byte
        wdata_o = ~wd;
        last_data = (rsp_valid_i === 1'b1) ? rsp_data_i : 8'hxx;
        last_ref = refused_i;
        // busy after a write or erase, bounded wait
        for (int i = 0; i < 64 && ready_i !== 1'b1; i++) @(negedge clock_i);
    endtask
endmodule // fsc_prog_model

// file: testbench/tb.sv
`timescale 1ns/1ps
// self-checking bench for the configuration store
module tb;
    localparam logic [7:0] SIG [3] = '{8'h5a, 8'h3c, 8'h0f}; // arbitrary identity values
    localparam logic [7:0] CAL = 8'ha5; // arbitrary trim value
    logic        clock_i = 1'b0, rst_b_i = 1'b0, sys_reset_i = 1'b0;
    logic        prog_mode_i = 1'b1, prog_serial_i = 1'b0;
    logic [11:0] pc_i = 12'habc;
    logic [8:0]  eea_i = 9'h1a7;
    logic        fe_seen = 1'b0, ee_seen = 1'b0; // sticky erase strobes
    int          err_total = 0, n_compared = 0;
    wire         v, w, e, rdy, rv, rf, fe, ee, spa;
    wire [2:0]   sp;
    wire [1:0]   ad, eb;
    wire [7:0]   wd, rd, lk, trim, hi_w, lo_w, ex_w;
    wire [4:0]   wpi;
    wire [6:0]   psi, ep;
    assign ex_w[7:3] = 5'h1f; // unused ext bits read 1
    fsc_store #(.WRITE_CYCLES(16'h0002), .ERASE_CYCLES(16'h0002), .SIG_BYTE0(SIG[0]),
                .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) i_dut (
        .clock_i, .rst_b_i, .sys_reset_i, .prog_mode_i, .prog_serial_i, .pc_i, .eea_i,
        .req_valid_i(v), .req_write_i(w), .req_erase_i(e), .req_space_i(sp),
        .req_addr_i(ad), .req_wdata_i(wd), .req_ready_o(rdy), .rsp_valid_o(rv),
        .rsp_data_o(rd), .refused_o(rf), .flash_erase_o(fe), .eeprom_erase_o(ee),
        .self_program_allow_o(spa), .reset_vector_sel_o(ex_w[0]), .boot_size_sel_hi_o(ex_w[2]),
        .boot_size_sel_lo_o(ex_w[1]), .ext_reset_off_o(hi_w[7]), .onchip_debug_on_o(hi_w[6]),
        .serial_prog_allow_o(hi_w[5]), .watchdog_forced_on_o(hi_w[4]),
        .eeprom_keep_on_erase_o(hi_w[3]), .brownout_level_o(hi_w[2:0]),
        .clock_div_eight_o(lo_w[7]), .clock_pin_output_o(lo_w[6]), .startup_time_o(lo_w[5:4]),
        .clock_source_o(lo_w[3:0]), .lock_bits_o(lk), .rc_osc_trim_reg_o(trim),
        .word_in_page_index_o(wpi), .page_select_index_o(psi), .ee_byte_o(eb), .ee_page_o(ep));
    fsc_prog_model i_prog (.clock_i, .ready_i(rdy), .rsp_valid_i(rv), .rsp_data_i(rd),
        .refused_i(rf), .valid_o(v), .write_o(w), .erase_o(e), .space_o(sp), .addr_o(ad),
        .wdata_o(wd));
    always #2 clock_i = ~clock_i;
    // erase strobes are one cycle wide, so keep a sticky copy
    always @(posedge clock_i) begin
        if (fe) fe_seen <= 1'b1;
        if (ee) ee_seen <= 1'b1;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdb(input logic [2:0] s, input logic [1:0] a);
        i_prog.xfer(1'b0, 1'b0, s, a, 8'h00);
    endtask
    task automatic wrb(input logic [2:0] s, input logic [7:0] d);
        i_prog.xfer(1'b1, 1'b0, s, 2'h0, d);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // factory images on the working outputs, trim reload on warm reset
    task automatic t_defaults;
        chk("ext", ex_w, 8'hf9);
        chk("self prog", {7'h0, spa}, 8'h01);
        chk("high", hi_w, 8'hdf);
        chk("low", lo_w, 8'h62);
        chk("lock", lk, 8'hff);
        sys_reset_i = 1'b1;
        @(negedge clock_i);
        sys_reset_i = 1'b0;
        chk("trim", trim, CAL);
        $display("defaults done");
    endtask
    // signature, calibration, read-only places
    task automatic t_reads;
        for (int i = 0; i < 3; i++) begin
            rdb(3'h4, i[1:0]);
            chk("sig", i_prog.last_data, SIG[i]);
        end
        rdb(3'h5, 2'h0);
        chk("cal", i_prog.last_data, CAL);
        wrb(3'h4, 8'h00);
        chk("sig refused", {7'h0, i_prog.last_ref}, 8'h01);
        rdb(3'h4, 2'h0);
        chk("sig kept", i_prog.last_data, SIG[0]);
        rdb(3'h1, 2'h0);
        chk("high read", i_prog.last_data, 8'hdf);
        $display("reads done");
    endtask
    // new fuses wait for mode exit, except the eeprom keep bit
    task automatic t_latch;
        wrb(3'h2, 8'h00);
        rdb(3'h2, 2'h0);
        chk("low stored", i_prog.last_data, 8'h00);
        chk("low held", lo_w, 8'h62);
        wrb(3'h0, 8'h00);
        rdb(3'h0, 2'h0);
        chk("ext stored", i_prog.last_data, 8'hf8);
        chk("ext held", ex_w, 8'hf9);
        wrb(3'h1, 8'hd7);
        repeat (2) @(negedge clock_i);
        chk("keep at once", hi_w, 8'hd7);
        prog_mode_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk("low on exit", lo_w, 8'h00);
        chk("ext on exit", ex_w, 8'hf8);
        prog_mode_i = 1'b1;
        repeat (3) @(negedge clock_i);
        $display("latch done");
    endtask
    // serial mode neither alters nor shows the serial allow bit
    task automatic t_serial;
        prog_serial_i = 1'b1;
        wrb(3'h1, 8'hff);
        rdb(3'h1, 2'h0);
        chk("serial view", i_prog.last_data, 8'hff);
        prog_serial_i = 1'b0;
        rdb(3'h1, 2'h0);
        chk("allow kept", i_prog.last_data, 8'hdf);
        $display("serial done");
    endtask
    // lock written after the fuses, then erase; working keep bit is programmed
    task automatic t_lock_erase;
        wrb(3'h3, 8'hfe);
        wrb(3'h2, 8'h11);
        chk("fuse refused", {7'h0, i_prog.last_ref}, 8'h01);
        rdb(3'h2, 2'h0);
        chk("fuse kept", i_prog.last_data, 8'h00);
        rdb(3'h4, 2'h1);
        chk("sig locked", i_prog.last_data, SIG[1]);
        i_prog.xfer(1'b0, 1'b1, 3'h0, 2'h0, 8'h00);
        repeat (2) @(negedge clock_i);
        chk("lock erased", lk, 8'hff);
        chk("flash erase", {7'h0, fe_seen}, 8'h01);
        chk("eeprom spared", {7'h0, ee_seen}, 8'h00);
        rdb(3'h2, 2'h0);
        chk("fuse after erase", i_prog.last_data, 8'h00);
        $display("erase done");
    endtask
    // page geometry slices
    task automatic t_geom;
        chk("word", {3'h0, wpi}, 8'h1c);
        chk("page", {1'h0, psi}, 8'h55);
        chk("ee byte", {6'h0, eb}, 8'h03);
        chk("ee page", {1'h0, ep}, 8'h69);
        $display("geometry done");
    endtask
    initial begin
        repeat (3) @(negedge clock_i);
        rst_b_i = 1'b1;
        t_defaults;
        t_reads;
        t_latch;
        t_serial;
        t_lock_erase;
        t_geom;
        tally_and_finish;
    end
    // whole run is under a hundred cycles
    initial begin
        repeat (4000) @(posedge clock_i);
        err_total++;
        tally_and_finish;
    end
endmodule // tb
